// [rtl/lbam_bucket.sv]
`timescale 1ns/1ps
`default_nettype none

module lbam_bucket
  import lbam_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                cycle_end,
  input  wire logic                cycle_bad,
  lbam_cfg_if.dst                  cfg,
  output var  logic [LEVEL_W-1:0]  level,
  output var  logic                alarm
);

  logic [LEVEL_W-1:0] level_reg;
  logic [LEVEL_W-1:0] level_next;
  logic [RUN_W-1:0]   run_reg;
  logic [RUN_W-1:0]   run_next;
  logic               alarm_reg;
  logic               alarm_next;

  wire logic [RUN_W-1:0] run_last;
  wire logic             leak_due;
  wire logic             at_top;
  wire logic             at_floor;

  // Code 0..3 gives a quiet run of 1, 2, 4 or 8 cycles per leak.
  assign run_last = RUN_W'((4'h1 << cfg.leak_code) - 4'h1);
  // A run already past the new limit after a leak code change leaks at once.
  assign leak_due = (run_reg >= run_last);
  assign at_top   = (level_reg == {LEVEL_W{1'b1}});
  assign at_floor = (level_reg == '0);

  always_comb
  begin
    level_next = level_reg;
    run_next   = run_reg;
    if (cycle_end)
    begin
      if (cycle_bad)
      begin
        run_next = '0;
        if (!at_top)
        begin
          level_next = level_reg + LEVEL_W'(1);
        end
      end
      else if (leak_due)
      begin
        run_next = '0;
        if (!at_floor)
        begin
          level_next = level_reg - LEVEL_W'(1);
        end
      end
      else
      begin
        run_next = run_reg + RUN_W'(1);
      end
    end
  end

  // The alarm is judged only at cycle ends, whether or not the accumulator moves.
  // A level write or a change of configuration between cycle ends cannot flip it.
  always_comb
  begin
    alarm_next = alarm_reg;
    if (cycle_end)
    begin
      if (level_next >= cfg.raise_level)
      begin
        alarm_next = 1'b1;
      end
      else if (level_next <= cfg.clear_level)
      begin
        alarm_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      level_reg <= '0;
      run_reg   <= '0;
      alarm_reg <= 1'b0;
    end
    else
    begin
      level_reg <= level_next;
      run_reg   <= run_next;
      alarm_reg <= alarm_next;
    end
  end

  assign level = level_reg;
  assign alarm = alarm_reg;

endmodule : lbam_bucket

`default_nettype wire

// [rtl/lbam_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface lbam_cfg_if;
  import lbam_pkg::*;

  logic [LEVEL_W-1:0] raise_level;
  logic [LEVEL_W-1:0] clear_level;
  logic [LEAK_W-1:0]  leak_code;

  modport src (output raise_level, output clear_level, output leak_code);
  modport dst (input raise_level, input clear_level, input leak_code);

endinterface : lbam_cfg_if

`default_nettype wire

// [rtl/lbam_monitor.sv]
// Behaviour
// - The monitored input is judged once per 128 ms cycle and the accumulator moves at its end.
// - Each cycle that saw a failure or erratic flag adds exactly one to the accumulator, which holds at 255.
// - Each unbroken quiet run of 1, 2, 4 or 8 cycles, per the leak code, takes one away unless the count is zero.
// - The inactivity alarm rises when the count reaches the 8-bit raise level in use.
// - A raised alarm drops when the count falls to the 8-bit clear level in use.
// - The second configuration leaks at the rate of its own leak register, apart from the first.
// - Leak codes 00, 01 and 10 give one leak per 128 ms, 256 ms and 512 ms.
`timescale 1ns/1ps
`default_nettype none

module lbam_monitor
  import lbam_pkg::*;
#(
  parameter int unsigned        CYCLE_CLKS  = MON_CYCLE_CLKS,
  parameter logic [LEVEL_W-1:0] SET1_RAISE  = SET1_RAISE_LEVEL_DEF,
  parameter logic [LEVEL_W-1:0] SET1_CLEAR  = SET1_CLEAR_LEVEL_DEF
)
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        input_failed,
  input  wire logic                        input_erratic,
  input  wire logic                        use_set2,
  input  wire logic [lbam_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [lbam_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  logic [lbam_pkg::DATA_W-1:0] reg_rdata,
  output var  logic                        reg_rvalid,
  output var  logic                        cycle_end,
  output var  logic [lbam_pkg::LEVEL_W-1:0] bucket_level,
  output var  logic                        inactivity_alarm
);

  if (CYCLE_CLKS < 2)
  begin : g_cycle_check
    $error("CYCLE_CLKS must be at least 2");
  end
  if (SET1_CLEAR >= SET1_RAISE)
  begin : g_level_check
    $error("SET1_CLEAR must lie below SET1_RAISE");
  end

  localparam int unsigned TICK_W = $clog2(CYCLE_CLKS);

  logic [TICK_W-1:0]  tick_reg;
  logic               tick_end_reg;
  logic               bad_seen_reg;
  logic [LEAK_W-1:0]  leak_set1_reg;
  logic [LEAK_W-1:0]  leak_set2_reg;
  logic [LEVEL_W-1:0] raise_set2_reg;
  logic [LEVEL_W-1:0] clear_set2_reg;
  logic [DATA_W-1:0]  rdata_reg;
  logic               rvalid_reg;
  logic [DATA_W-1:0]  rdata_next;

  wire logic              tick_wrap;
  wire logic              bad_now;
  wire logic              cycle_bad;
  wire logic              wr_leak1;
  wire logic              wr_leak2;
  wire logic              wr_raise2;
  wire logic              wr_clear2;
  wire logic [LEVEL_W-1:0] level;
  wire logic              alarm;

  lbam_cfg_if cfg ();

  assign tick_wrap = (tick_reg == TICK_W'(CYCLE_CLKS - 1));
  assign bad_now   = input_failed | input_erratic;
  // A flag seen on the closing clock still counts for the cycle that ends.
  assign cycle_bad = bad_seen_reg | bad_now;

  assign wr_leak1  = reg_wr && (reg_addr == BUCKET_LEAK_PERIOD_SET1_OFS);
  assign wr_leak2  = reg_wr && (reg_addr == BUCKET_LEAK_PERIOD_SET2_OFS);
  assign wr_raise2 = reg_wr && (reg_addr == BUCKET_ALARM_RAISE_LEVEL_SET2_OFS);
  assign wr_clear2 = reg_wr && (reg_addr == BUCKET_ALARM_CLEAR_LEVEL_SET2_OFS);

  // The configuration in use supplies levels and its own leak code.
  assign cfg.raise_level = use_set2 ? raise_set2_reg : SET1_RAISE;
  assign cfg.clear_level = use_set2 ? clear_set2_reg : SET1_CLEAR;
  assign cfg.leak_code   = use_set2 ? leak_set2_reg  : leak_set1_reg;

  always_comb
  begin
    rdata_next = '0;
    case (reg_addr)
      BUCKET_LEAK_PERIOD_SET1_OFS:       rdata_next[LEAK_LSB +: LEAK_W] = leak_set1_reg;
      BUCKET_LEAK_PERIOD_SET2_OFS:       rdata_next[LEAK_LSB +: LEAK_W] = leak_set2_reg;
      BUCKET_ALARM_RAISE_LEVEL_SET2_OFS: rdata_next = raise_set2_reg;
      BUCKET_ALARM_CLEAR_LEVEL_SET2_OFS: rdata_next = clear_set2_reg;
      BUCKET_LEVEL_OFS:                  rdata_next = level;
      BUCKET_ALARM_STATE_OFS:            rdata_next[ALARM_STATE_BIT] = alarm;
      default:                           rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tick_reg     <= '0;
      tick_end_reg <= 1'b0;
      bad_seen_reg <= 1'b0;
    end
    else
    begin
      tick_reg     <= tick_wrap ? '0 : tick_reg + TICK_W'(1);
      tick_end_reg <= tick_wrap;
      bad_seen_reg <= tick_wrap ? 1'b0 : cycle_bad;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      leak_set1_reg  <= BUCKET_LEAK_PERIOD_SET1_RST;
      leak_set2_reg  <= BUCKET_LEAK_PERIOD_SET2_RST;
      raise_set2_reg <= BUCKET_ALARM_RAISE_LEVEL_SET2_RST;
      clear_set2_reg <= BUCKET_ALARM_CLEAR_LEVEL_SET2_RST;
    end
    else
    begin
      if (wr_leak1)  leak_set1_reg  <= reg_wdata[LEAK_LSB +: LEAK_W];
      if (wr_leak2)  leak_set2_reg  <= reg_wdata[LEAK_LSB +: LEAK_W];
      if (wr_raise2) raise_set2_reg <= reg_wdata;
      if (wr_clear2) clear_set2_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= reg_rd;
      if (reg_rd) rdata_reg <= rdata_next;
    end
  end

  lbam_bucket u_bucket (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .cycle_end (tick_wrap),
    .cycle_bad (cycle_bad),
    .cfg       (cfg.dst),
    .level     (level),
    .alarm     (alarm)
  );

  assign reg_rdata        = rdata_reg;
  assign reg_rvalid       = rvalid_reg;
  assign cycle_end        = tick_end_reg;
  assign bucket_level     = level;
  assign inactivity_alarm = alarm;

endmodule : lbam_monitor

`default_nettype wire

// [rtl/lbam_pkg.sv]
package lbam_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned MON_CYCLE_MS = 128;
  localparam int unsigned MON_CYCLE_CLKS =
    int'((64'(MON_CYCLE_MS) * 64'(CLK_HZ)) / 64'd1000);

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LEVEL_W = 8;
  localparam int unsigned LEAK_W = 2;
  localparam int unsigned RUN_W = 3;

  localparam logic [ADDR_W-1:0] BUCKET_LEAK_PERIOD_SET1_OFS   = 7'h57;
  localparam logic [ADDR_W-1:0] BUCKET_ALARM_RAISE_LEVEL_SET2_OFS = 7'h58;
  localparam logic [ADDR_W-1:0] BUCKET_ALARM_CLEAR_LEVEL_SET2_OFS = 7'h59;
  localparam logic [ADDR_W-1:0] BUCKET_LEAK_PERIOD_SET2_OFS   = 7'h5B;
  localparam logic [ADDR_W-1:0] BUCKET_LEVEL_OFS              = 7'h70;
  localparam logic [ADDR_W-1:0] BUCKET_ALARM_STATE_OFS        = 7'h71;

  localparam int unsigned LEAK_LSB = 0;
  localparam int unsigned ALARM_STATE_BIT = 0;

  localparam logic [LEAK_W-1:0]  BUCKET_LEAK_PERIOD_SET1_RST        = 2'h1;
  localparam logic [LEAK_W-1:0]  BUCKET_LEAK_PERIOD_SET2_RST        = 2'h1;
  localparam logic [LEVEL_W-1:0] BUCKET_ALARM_CLEAR_LEVEL_SET2_RST  = 8'h04;
  localparam logic [LEVEL_W-1:0] BUCKET_ALARM_RAISE_LEVEL_SET2_RST  = 8'h06;
  localparam logic [LEVEL_W-1:0] SET1_RAISE_LEVEL_DEF               = 8'h06;
  localparam logic [LEVEL_W-1:0] SET1_CLEAR_LEVEL_DEF               = 8'h04;

  localparam logic [LEAK_W-1:0] LEAK_EVERY_1 = 2'h0;
  localparam logic [LEAK_W-1:0] LEAK_EVERY_2 = 2'h1;
  localparam logic [LEAK_W-1:0] LEAK_EVERY_4 = 2'h2;
  localparam logic [LEAK_W-1:0] LEAK_EVERY_8 = 2'h3;

endpackage : lbam_pkg

// [tb/lbam_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module lbam_checker
  import lbam_pkg::*;
#(parameter int unsigned CYCLE_CLKS = 8)
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       input_failed,
  input wire logic       input_erratic,
  input wire logic       use_set2,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       cycle_end,
  input wire logic [7:0] bucket_level,
  input wire logic       inactivity_alarm
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [31:0] cnt_reg;
  logic        bad_reg;
  logic [7:0]  up_reg;
  logic [7:0]  dn_reg;
  wire         close = cnt_reg == CYCLE_CLKS - 1;
  wire         bad = bad_reg | input_failed | input_erratic;
  wire [7:0]   up = use_set2 ? up_reg : SET1_RAISE_LEVEL_DEF;
  wire [7:0]   dn = use_set2 ? dn_reg : SET1_CLEAR_LEVEL_DEF;
  // Shadow of the set 2 levels so the alarm can be judged without a back door.
  always_ff @(posedge clk)
  begin
    cnt_reg <= (sys_rst || close) ? 32'h0 : cnt_reg + 32'h1;
    bad_reg <= !sys_rst && !close && bad;
    up_reg <= sys_rst ? 8'h06 : (reg_wr && reg_addr == 7'h58) ? reg_wdata : up_reg;
    dn_reg <= sys_rst ? 8'h04 : (reg_wr && reg_addr == 7'h59) ? reg_wdata : dn_reg;
  end
  a_cycle_mark: assert property (cycle_end == $past(close))
    else $error("cycle mark off grid");
  a_level_moves: assert property ($changed(bucket_level) |-> $past(close))
    else $error("level moved mid cycle");
  a_bad_adds: assert property (close && bad && bucket_level != 8'hFF |=>
    bucket_level == $past(bucket_level) + 8'h01) else $error("bad cycle not plus one");
  a_quiet_leak: assert property (close && !bad |=> bucket_level == $past(bucket_level)
    || bucket_level == $past(bucket_level) - 8'h01) else $error("quiet cycle step");
  a_alarm_raise: assert property ($past(close) && bucket_level >= $past(up) |-> inactivity_alarm)
    else $error("alarm not raised");
  a_alarm_clear: assert property ($past(close) && bucket_level <= $past(dn) &&
    bucket_level < $past(up) |-> !inactivity_alarm) else $error("alarm not cleared");
  a_alarm_moves: assert property ($changed(inactivity_alarm) |-> $past(close))
    else $error("alarm moved mid cycle");
  a_read_level: assert property (reg_rd && reg_addr == 7'h70 |=>
    reg_rvalid && reg_rdata == $past(bucket_level)) else $error("level read wrong");
  c_alarm_up: cover property ($rose(inactivity_alarm));
  c_alarm_down: cover property ($fell(inactivity_alarm));
  c_bad_close: cover property (close && bad);
endmodule : lbam_checker
bind lbam_monitor lbam_checker #(.CYCLE_CLKS(CYCLE_CLKS)) i_lbam_checker (
  .clk              (clk),
  .sys_rst          (sys_rst),
  .input_failed     (input_failed),
  .input_erratic    (input_erratic),
  .use_set2         (use_set2),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_wr           (reg_wr),
  .reg_rd           (reg_rd),
  .reg_rdata        (reg_rdata),
  .reg_rvalid       (reg_rvalid),
  .cycle_end        (cycle_end),
  .bucket_level     (bucket_level),
  .inactivity_alarm (inactivity_alarm)
);
`default_nettype wire

// [tb/lbam_quality_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lbam_quality_model
(
  input  wire logic       clk,
  input  wire logic [1:0] bad_cmd,
  output var  logic       input_failed,
  output var  logic       input_erratic
);
  // Flags are registered on the rising edge, as quality logic on this clock would do.
  always @(posedge clk)
  begin
    input_failed <= bad_cmd == 2'h1;
    input_erratic <= bad_cmd == 2'h2;
  end
endmodule : lbam_quality_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic w; logic [6:0] a; logic [7:0] d; logic [7:0] q;} lbam_row_t;
  lbam_row_t  rows [11] = '{'{0, 7'h57, 8'h00, 8'h01}, '{0, 7'h58, 8'h00, 8'h06},
    '{0, 7'h59, 8'h00, 8'h04}, '{0, 7'h5B, 8'h00, 8'h01}, '{1, 7'h57, 8'hFF, 8'h03},
    '{1, 7'h5B, 8'hFE, 8'h02}, '{1, 7'h58, 8'hA5, 8'hA5}, '{1, 7'h59, 8'h3C, 8'h3C},
    '{1, 7'h10, 8'h55, 8'h00}, '{1, 7'h70, 8'h11, 8'h00}, '{1, 7'h71, 8'hFF, 8'h00}};
  logic       clk = 1'b1;
  logic       sys_rst = 1'b1;
  logic       use_set2 = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] bad_cmd = 2'h0;
  logic       input_failed, input_erratic, reg_rvalid, cycle_end, inactivity_alarm;
  logic [7:0] reg_rdata, bucket_level;
  int         err_total = 0;
  int         compares = 0;
  int         ticks = 0;
  lbam_quality_model i_lbam_quality_model (
    .clk           (clk),
    .bad_cmd       (bad_cmd),
    .input_failed  (input_failed),
    .input_erratic (input_erratic)
  );
  lbam_monitor #(.CYCLE_CLKS(8)) i_lbam_monitor (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .input_failed     (input_failed),
    .input_erratic    (input_erratic),
    .use_set2         (use_set2),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .reg_rvalid       (reg_rvalid),
    .cycle_end        (cycle_end),
    .bucket_level     (bucket_level),
    .inactivity_alarm (inactivity_alarm)
  );
  initial
  begin
    forever #20 clk = ~clk;
  end
  task print_verdict;
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [6:0] a, input logic [7:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({reg_rvalid, reg_rdata}, {1'b1, q});
  endtask : rd
  task wait_mark;
    @(negedge clk);
    while (cycle_end !== 1'b1)
      @(negedge clk);
  endtask : wait_mark
  // One monitoring cycle with an optional one-clock flag, then level and alarm.
  task cyc(input logic [1:0] b, input logic [7:0] q, input logic al);
    @(negedge clk);
    bad_cmd = b;
    @(negedge clk);
    bad_cmd = 2'h0;
    wait_mark();
    chk({inactivity_alarm, bucket_level}, {al, q});
  endtask : cyc
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 2000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    wait_mark();
    wr(7'h57, 8'h00);
    for (int i = 1; i <= 6; i++)
      cyc(i[0] ? 2'h1 : 2'h2, 8'(i), i == 6);
    cyc(2'h0, 8'h05, 1'b1);
    cyc(2'h0, 8'h04, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      wr(7'h57, 8'(c));
      cyc(2'h1, 8'h05, 1'b0);
      repeat ((1 << c) - 1) cyc(2'h0, 8'h05, 1'b0);
      cyc(2'h0, 8'h04, 1'b0);
    end
    wr(7'h5B, 8'h00);
    wr(7'h58, 8'h05);
    wr(7'h59, 8'h02);
    wait_mark();
    use_set2 = 1'b1;
    cyc(2'h2, 8'h05, 1'b1);
    cyc(2'h0, 8'h04, 1'b1);
    cyc(2'h0, 8'h03, 1'b1);
    cyc(2'h0, 8'h02, 1'b0);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk({inactivity_alarm, bucket_level}, 9'h000);
    chk({reg_rvalid, 7'h00, cycle_end}, 9'h000);
    rd(7'h57, 8'h01);
    rd(7'h5B, 8'h01);
    rd(7'h58, 8'h06);
    rd(7'h59, 8'h04);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
